// ==== rtl/piu_defs.svh ====
// Register offsets, reset values and timing counts of the parallel I/O unit
`ifndef PIU_DEFS_SVH
`define PIU_DEFS_SVH

// Register byte offsets
`define PIU_OFF_OWNER_SET 8'h00
`define PIU_OFF_OWNER_CLR 8'h04
`define PIU_OFF_OWNER_STATE 8'h08
`define PIU_OFF_DRIVE_SET 8'h10
`define PIU_OFF_DRIVE_CLR 8'h14
`define PIU_OFF_DRIVE_STATE 8'h18
`define PIU_OFF_FILT_SET 8'h20
`define PIU_OFF_FILT_CLR 8'h24
`define PIU_OFF_FILT_STATE 8'h28
`define PIU_OFF_OUT_SET 8'h30
`define PIU_OFF_OUT_CLR 8'h34
`define PIU_OFF_OUT_STATE 8'h38
`define PIU_OFF_PIN_LEVEL 8'h3c
`define PIU_OFF_IRQ_SET 8'h40
`define PIU_OFF_IRQ_CLR 8'h44
`define PIU_OFF_IRQ_MASK 8'h48
`define PIU_OFF_CHG_FLAGS 8'h4c
`define PIU_OFF_OD_SET 8'h50
`define PIU_OFF_OD_CLR 8'h54
`define PIU_OFF_OD_STATE 8'h58
`define PIU_OFF_PULL_OFF 8'h60
`define PIU_OFF_PULL_ON 8'h64
`define PIU_OFF_PULL_STATE 8'h68
`define PIU_OFF_FUNC_A 8'h70
`define PIU_OFF_FUNC_B 8'h74
`define PIU_OFF_FUNC_STATE 8'h78
`define PIU_OFF_WMASK_SET 8'ha0
`define PIU_OFF_WMASK_CLR 8'ha4
`define PIU_OFF_WMASK_STATE 8'ha8

// Reset values
`define PIU_RST_ZERO 32'h0000_0000
`define PIU_RST_OWNER 32'hffff_ffff
`define PIU_RST_LINES 32'hffff_ffff

// Filter delay in controller clock cycles when a line filter is on
`define PIU_FILT_LAT_CYC 1

// AXI response code
`define PIU_RESP_OKAY 2'h0

`endif

// ==== rtl/piu_pkg.sv ====
// Types shared by the parallel I/O unit modules
package piu_pkg;

  typedef logic [31:0] piu_word_t;

  // Input stage state: two synchroniser flops and the filter delay flop
  typedef struct packed {
    piu_word_t meta;
    piu_word_t sync;
    piu_word_t delay;
  } piu_stage_s;

  // Core state: bus slave, configuration and input tracking
  typedef struct packed {
    logic awRdy;
    logic wRdy;
    logic bValid;
    logic arRdy;
    logic rValid;
    logic awFull;
    logic wFull;
    logic [7:0] awAddr;
    piu_word_t wData;
    logic [3:0] wStrb;
    piu_word_t rData;
    piu_word_t owner;
    piu_word_t driveEn;
    piu_word_t filtEn;
    piu_word_t outLevel;
    piu_word_t irqMask;
    piu_word_t flags;
    piu_word_t openDrain;
    piu_word_t pullOff;
    piu_word_t funcB;
    piu_word_t owMask;
    piu_word_t pinLevel;
    piu_word_t prevLevel;
    logic irq;
  } piu_core_s;

endpackage : piu_pkg

// ==== rtl/piu_line_if.sv ====
// Connection between the core and its input stage
interface piu_line_if;
  logic clkOn;
  piu_pkg::piu_word_t filtEn;
  piu_pkg::piu_word_t rawSync;
  piu_pkg::piu_word_t filtered;

  modport stage (input clkOn, input filtEn, output rawSync, output filtered);
  modport core (output clkOn, output filtEn, input rawSync, input filtered);
endinterface : piu_line_if

// ==== rtl/piu_in_stage.sv ====
// Input synchroniser and per-line one-cycle filter delay of the parallel I/O unit
`include "piu_defs.svh"

module piu_in_stage #(
  parameter int W = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Pad levels
  input wire logic [31:0] pinIn,
  // Core side
  piu_line_if.stage lines
);

  piu_pkg::piu_stage_s st_reg;
  piu_pkg::piu_stage_s st_next;

  if (W < 1 || W > 32) begin : g_chk
    $error("piu_in_stage: W must be 1 to 32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sampling freezes while the controller clock is off, so levels hold
  always_comb begin
    st_next = st_reg;
    if (lines.clkOn) begin
      st_next.meta = pinIn;
      st_next.sync = st_reg.meta;
      st_next.delay = st_reg.sync;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Peripherals see the unfiltered level; filtered lines lag one cycle
  assign lines.rawSync = st_reg.sync;
  assign lines.filtered = (st_reg.sync & ~lines.filtEn) | (st_reg.delay & lines.filtEn);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_filt_latency;
    @(posedge clk) disable iff (!rst_b)
      (lines.clkOn && lines.filtEn[0])
        |=> (!lines.filtEn[0] || lines.filtered[0] == $past(st_reg.sync[0]));
  endproperty
  a_filt_latency: assert property (p_filt_latency) else $error("filter delay");

  property p_raw_unfiltered;
    @(posedge clk) disable iff (!rst_b)
      lines.clkOn |=> (lines.rawSync == $past(st_reg.meta));
  endproperty
  a_raw_unfiltered: assert property (p_raw_unfiltered) else $error("raw level");

endmodule : piu_in_stage

// ==== rtl/piu_core.sv ====
// Parallel I/O unit: input sampling, filtering, change events and registers
// Functional notes
// - Pin level register shows the filtered sampled level while clock on
// - Clock off: pin level holds last sample
// - Filter is a one-cycle delay: a glitch sampled at a rising edge passes; full cycles pass
// - Filter adds one cycle latency
// - Filter set/clear writes steer filter state
// - Filter never touches peripheral input levels
// - Filter works only with clock on
// - Change detection compares two clocked samples
// - Irq enable/disable writes steer mask
// - Change detection on every line while clock on
// - Change sets flag; masked flag raises irq
// - All masked flags ORed to one irq
// - Reading change flags clears them all
// - 32-bit registers, bit n is line n
// - Missing lines: writes ignored, reads zero
// - Unmuxed lines always read owned as 1
// - Direct output write only on masked bits
// - Change flags reset to zero
// - Owner reset value is a parameter
// - Function A write clears, B sets
// - Function bit 0 is A, 1 is B
// - Pull-up state 1 means pull-up off
// - Output set/clear writes steer output level
`include "piu_defs.svh"

module piu_core #(
  parameter logic [31:0] LINE_MASK = `PIU_RST_LINES,
  parameter logic [31:0] MUX_MASK = `PIU_RST_LINES,
  parameter logic [31:0] OWNER_RESET = `PIU_RST_OWNER
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Controller clock gate from power management
  input wire logic ctlClkOn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pads
  input wire logic [31:0] pinIn,
  output logic [31:0] periphIn,
  output logic [31:0] ownerIsCtl,
  output logic [31:0] driveEnable,
  output logic [31:0] outLevel,
  output logic [31:0] openDrain,
  output logic [31:0] pullupOff,
  output logic [31:0] funcBSelect,
  // Interrupt toward the system interrupt controller
  output logic changeIrq
);

  piu_pkg::piu_core_s st_reg;
  piu_pkg::piu_core_s st_next;
  piu_line_if lineBus ();
  logic awHs;
  logic wHs;
  logic arHs;
  logic doWrite;
  logic flagRead;
  piu_pkg::piu_word_t byteMask;
  piu_pkg::piu_word_t wBits;
  piu_pkg::piu_word_t changeVec;
  piu_pkg::piu_word_t readVal;

  if ((OWNER_RESET & ~MUX_MASK & LINE_MASK) != (~MUX_MASK & LINE_MASK)) begin : g_chk
    $error("piu_core: unmuxed lines must reset as owned");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input stage
  piu_in_stage #(
    .W(32)
  ) u_in_stage (
    .clk(clk),
    .rst_b(rst_b),
    .pinIn(pinIn),
    .lines(lineBus.stage)
  );

  // Stage clock gate comes straight from ctlClkOn, filter enables from state
  assign lineBus.clkOn = ctlClkOn;
  assign lineBus.filtEn = st_reg.filtEn;

  ////////////////////////////////////////////////////////////////////////////
  // Handshakes and write data lanes
  assign awHs = s_axi_awvalid && st_reg.awRdy;
  assign wHs = s_axi_wvalid && st_reg.wRdy;
  assign arHs = s_axi_arvalid && st_reg.arRdy;
  assign doWrite = st_reg.awFull && st_reg.wFull && !st_reg.bValid;
  assign flagRead = arHs && ({s_axi_araddr[7:2], 2'h0} == `PIU_OFF_CHG_FLAGS);
  assign byteMask = {{8{st_reg.wStrb[3]}}, {8{st_reg.wStrb[2]}},
                     {8{st_reg.wStrb[1]}}, {8{st_reg.wStrb[0]}}};
  assign wBits = st_reg.wData & byteMask & LINE_MASK;

  // Change between two successive clocked samples, all lines
  assign changeVec = ctlClkOn ? ((lineBus.filtered ^ st_reg.prevLevel) & LINE_MASK)
                              : '0;

  ////////////////////////////////////////////////////////////////////////////
  // Read decode; write-only and reserved words read zero
  always_comb begin
    unique case ({s_axi_araddr[7:2], 2'h0})
      `PIU_OFF_OWNER_STATE: readVal = st_reg.owner | ~MUX_MASK;
      `PIU_OFF_DRIVE_STATE: readVal = st_reg.driveEn;
      `PIU_OFF_FILT_STATE: readVal = st_reg.filtEn;
      `PIU_OFF_OUT_STATE: readVal = st_reg.outLevel;
      `PIU_OFF_PIN_LEVEL: readVal = st_reg.pinLevel;
      `PIU_OFF_IRQ_MASK: readVal = st_reg.irqMask;
      `PIU_OFF_CHG_FLAGS: readVal = st_reg.flags;
      `PIU_OFF_OD_STATE: readVal = st_reg.openDrain;
      `PIU_OFF_PULL_STATE: readVal = st_reg.pullOff;
      `PIU_OFF_FUNC_STATE: readVal = st_reg.funcB;
      `PIU_OFF_WMASK_STATE: readVal = st_reg.owMask;
      default: readVal = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_next = st_reg;
    // Write channel capture, each channel on its own
    if (awHs) begin
      st_next.awAddr = {s_axi_awaddr[7:2], 2'h0};
      st_next.awFull = 1'b1;
    end
    if (wHs) begin
      st_next.wData = s_axi_wdata;
      st_next.wStrb = s_axi_wstrb;
      st_next.wFull = 1'b1;
    end
    // Register write once address and data are both held
    if (doWrite) begin
      st_next.awFull = 1'b0;
      st_next.wFull = 1'b0;
      st_next.bValid = 1'b1;
      unique case (st_reg.awAddr)
        `PIU_OFF_OWNER_SET: st_next.owner = st_reg.owner | (wBits & MUX_MASK);
        `PIU_OFF_OWNER_CLR: st_next.owner = st_reg.owner & ~(wBits & MUX_MASK);
        `PIU_OFF_DRIVE_SET: st_next.driveEn = st_reg.driveEn | wBits;
        `PIU_OFF_DRIVE_CLR: st_next.driveEn = st_reg.driveEn & ~wBits;
        `PIU_OFF_FILT_SET: st_next.filtEn = st_reg.filtEn | wBits;
        `PIU_OFF_FILT_CLR: st_next.filtEn = st_reg.filtEn & ~wBits;
        `PIU_OFF_OUT_SET: st_next.outLevel = st_reg.outLevel | wBits;
        `PIU_OFF_OUT_CLR: st_next.outLevel = st_reg.outLevel & ~wBits;
        `PIU_OFF_OUT_STATE: begin
          // Only write-masked bits follow the data, the rest stay
          st_next.outLevel = (st_reg.outLevel & ~(st_reg.owMask & byteMask & LINE_MASK))
                           | (wBits & st_reg.owMask);
        end
        `PIU_OFF_IRQ_SET: st_next.irqMask = st_reg.irqMask | wBits;
        `PIU_OFF_IRQ_CLR: st_next.irqMask = st_reg.irqMask & ~wBits;
        `PIU_OFF_OD_SET: st_next.openDrain = st_reg.openDrain | wBits;
        `PIU_OFF_OD_CLR: st_next.openDrain = st_reg.openDrain & ~wBits;
        `PIU_OFF_PULL_OFF: st_next.pullOff = st_reg.pullOff | wBits;
        `PIU_OFF_PULL_ON: st_next.pullOff = st_reg.pullOff & ~wBits;
        `PIU_OFF_FUNC_A: st_next.funcB = st_reg.funcB & ~wBits;
        `PIU_OFF_FUNC_B: st_next.funcB = st_reg.funcB | wBits;
        `PIU_OFF_WMASK_SET: st_next.owMask = st_reg.owMask | wBits;
        `PIU_OFF_WMASK_CLR: st_next.owMask = st_reg.owMask & ~wBits;
        default: st_next.bValid = 1'b1;
      endcase
    end
    if (st_reg.bValid && s_axi_bready) begin
      st_next.bValid = 1'b0;
    end
    // One write at a time: ready drops while held or answered
    st_next.awRdy = !st_next.awFull && !st_next.bValid;
    st_next.wRdy = !st_next.wFull && !st_next.bValid;
    // Read answers one cycle after the address is taken
    if (arHs) begin
      st_next.rData = readVal & LINE_MASK;
      st_next.rValid = 1'b1;
      st_next.arRdy = 1'b0;
    end else if (st_reg.rValid && s_axi_rready) begin
      st_next.rValid = 1'b0;
      st_next.arRdy = 1'b1;
    end
    // Sampled levels freeze while the controller clock is off
    if (ctlClkOn) begin
      st_next.pinLevel = lineBus.filtered & LINE_MASK;
      st_next.prevLevel = lineBus.filtered & LINE_MASK;
    end
    // Read clears all flags, but a change in that cycle still lands
    st_next.flags = (flagRead ? '0 : st_reg.flags) | changeVec;
    // Irq tracks the new flags with no extra cycle of lag
    st_next.irq = |(st_next.flags & st_next.irqMask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
      st_reg.owner <= OWNER_RESET | ~MUX_MASK;
      st_reg.awRdy <= 1'b1;
      st_reg.wRdy <= 1'b1;
      st_reg.arRdy <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flops
  assign s_axi_awready = st_reg.awRdy;
  assign s_axi_wready = st_reg.wRdy;
  assign s_axi_bvalid = st_reg.bValid;
  assign s_axi_bresp = `PIU_RESP_OKAY;
  assign s_axi_arready = st_reg.arRdy;
  assign s_axi_rvalid = st_reg.rValid;
  assign s_axi_rdata = st_reg.rData;
  assign s_axi_rresp = `PIU_RESP_OKAY;
  assign periphIn = lineBus.rawSync;
  assign ownerIsCtl = st_reg.owner | ~MUX_MASK;
  assign driveEnable = st_reg.driveEn;
  assign outLevel = st_reg.outLevel;
  assign openDrain = st_reg.openDrain;
  assign pullupOff = st_reg.pullOff;
  assign funcBSelect = st_reg.funcB;
  assign changeIrq = st_reg.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_flag_read_clears;
    @(posedge clk) disable iff (!rst_b)
      flagRead |=> (st_reg.flags == $past(changeVec));
  endproperty
  a_flag_read_clears: assert property (p_flag_read_clears) else $error("flags not cleared");

  property p_change_sets_flag;
    @(posedge clk) disable iff (!rst_b)
      (changeVec != '0) |=> ((st_reg.flags & $past(changeVec)) == $past(changeVec));
  endproperty
  a_change_sets_flag: assert property (p_change_sets_flag) else $error("change lost");

  property p_irq_or;
    @(posedge clk) disable iff (!rst_b)
      changeIrq == (|(st_reg.flags & st_reg.irqMask));
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq does not match masked flags");

  property p_irq_enable;
    @(posedge clk) disable iff (!rst_b)
      (doWrite && st_reg.awAddr == `PIU_OFF_IRQ_SET)
        |=> ((st_reg.irqMask & $past(wBits)) == $past(wBits));
  endproperty
  a_irq_enable: assert property (p_irq_enable) else $error("irq mask not set");

  property p_filt_disable;
    @(posedge clk) disable iff (!rst_b)
      (doWrite && st_reg.awAddr == `PIU_OFF_FILT_CLR) |=> ((st_reg.filtEn & $past(wBits)) == '0);
  endproperty
  a_filt_disable: assert property (p_filt_disable) else $error("filter not cleared");

  property p_direct_write_masked;
    @(posedge clk) disable iff (!rst_b)
      (doWrite && st_reg.awAddr == `PIU_OFF_OUT_STATE)
        |=> ((st_reg.outLevel & ~$past(st_reg.owMask))
             == ($past(st_reg.outLevel) & ~$past(st_reg.owMask)));
  endproperty
  a_direct_write_masked: assert property (p_direct_write_masked) else $error("bad write");

  property p_func_a_clears;
    @(posedge clk) disable iff (!rst_b)
      (doWrite && st_reg.awAddr == `PIU_OFF_FUNC_A) |=> ((st_reg.funcB & $past(wBits)) == '0);
  endproperty
  a_func_a_clears: assert property (p_func_a_clears) else $error("A did not clear");

  property p_level_holds;
    @(posedge clk) disable iff (!rst_b)
      !ctlClkOn |=> $stable(st_reg.pinLevel) && (st_reg.flags & ~$past(st_reg.flags)) == '0;
  endproperty
  a_level_holds: assert property (p_level_holds) else $error("sampling ran with clock off");

  property p_unmuxed_owned;
    @(posedge clk) disable iff (!rst_b)
      (arHs && {s_axi_araddr[7:2], 2'h0} == `PIU_OFF_OWNER_STATE)
        |=> s_axi_rvalid && ((s_axi_rdata & ~MUX_MASK) == (LINE_MASK & ~MUX_MASK));
  endproperty
  a_unmuxed_owned: assert property (p_unmuxed_owned) else $error("unmuxed line not owned");

  property p_missing_lines_zero;
    @(posedge clk) disable iff (!rst_b)
      s_axi_rvalid |-> ((s_axi_rdata & ~LINE_MASK) == '0);
  endproperty
  a_missing_lines_zero: assert property (p_missing_lines_zero) else $error("bad line bits");

  // Flags only ever grow until software reads them
  property p_flags_persist;
    @(posedge clk) disable iff (!rst_b)
      !flagRead |=> ((st_reg.flags & $past(st_reg.flags)) == $past(st_reg.flags));
  endproperty
  a_flags_persist: assert property (p_flags_persist) else $error("flag lost");

  property p_pin_level_follows;
    @(posedge clk) disable iff (!rst_b)
      ctlClkOn |=> (st_reg.pinLevel == $past(lineBus.filtered & LINE_MASK));
  endproperty
  a_pin_level_follows: assert property (p_pin_level_follows) else $error("pin level stale");

  property p_irq_disable;
    @(posedge clk) disable iff (!rst_b)
      (doWrite && st_reg.awAddr == `PIU_OFF_IRQ_CLR)
        |=> ((st_reg.irqMask & $past(wBits)) == '0);
  endproperty
  a_irq_disable: assert property (p_irq_disable) else $error("irq mask not cleared");

  property p_filt_enable;
    @(posedge clk) disable iff (!rst_b)
      (doWrite && st_reg.awAddr == `PIU_OFF_FILT_SET)
        |=> ((st_reg.filtEn & $past(wBits)) == $past(wBits));
  endproperty
  a_filt_enable: assert property (p_filt_enable) else $error("filter not set");

  property p_func_b_sets;
    @(posedge clk) disable iff (!rst_b)
      (doWrite && st_reg.awAddr == `PIU_OFF_FUNC_B)
        |=> ((st_reg.funcB & $past(wBits)) == $past(wBits));
  endproperty
  a_func_b_sets: assert property (p_func_b_sets) else $error("B did not set");

  property p_out_set;
    @(posedge clk) disable iff (!rst_b)
      (doWrite && st_reg.awAddr == `PIU_OFF_OUT_SET)
        |=> ((st_reg.outLevel & $past(wBits)) == $past(wBits));
  endproperty
  a_out_set: assert property (p_out_set) else $error("output not set");

endmodule : piu_core

// ==== tb/piu_pin_model.sv ====
// Pad-side model that drives the I/O line levels
module piu_pin_model (
  // Clock seen by the pads
  input wire logic clk,
  // Levels on the lines
  output logic [31:0] pinIn
);
  timeunit 1ns;
  timeprecision 100ps;

  // Lines start low so the first change is known
  initial pinIn = 32'h0;

  // Clean step launched just after a rising edge
  task automatic step(input logic [31:0] v);
    @(posedge clk);
    pinIn <= v;
  endtask : step

  // Pulse under half a cycle, kept clear of the rising edge
  task automatic glitch(input logic [31:0] m);
    @(negedge clk);
    #0.5 pinIn = pinIn ^ m;
    #1 pinIn = pinIn ^ m;
  endtask : glitch
endmodule : piu_pin_model

// ==== tb/testbench.sv ====
// Self-checking bench for the parallel I/O unit core
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  // Line 31 absent, line 0 without muxing
  localparam logic [31:0] LM = 32'h7fff_ffff;
  localparam logic [31:0] MM = 32'hffff_fffe;
  localparam logic [31:0] ORST = 32'h0000_00f0;

  logic clk, rst_b, ctlClkOn, changeIrq;
  logic [7:0] s_axi_awaddr, s_axi_araddr, a;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, pinIn, periphIn, ownerIsCtl;
  logic [31:0] driveEnable, outLevel, openDrain, pullupOff, funcBSelect;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] st [16];
  logic [31:0] prev, v;
  int n_fail = 0;
  int check_count = 0;
  int seed = 35;
  logic [7:0] wa [22] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h20, 8'h24, 8'h30, 8'h34,
    8'h38, 8'h40, 8'h44, 8'h50, 8'h54, 8'h60, 8'h64, 8'h70, 8'h74, 8'ha0, 8'ha4,
    8'h08, 8'h0c, 8'h4c};

  piu_core #(.LINE_MASK(LM), .MUX_MASK(MM), .OWNER_RESET(ORST)) DUT (.clk, .rst_b,
    .ctlClkOn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pinIn, .periphIn, .ownerIsCtl,
    .driveEnable, .outLevel, .openDrain, .pullupOff, .funcBSelect, .changeIrq);

  piu_pin_model PAD (.clk, .pinIn);

  //////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #100000;
    n_fail++;
    finish_test();
  end

  //////////////////////////////////////////////////////////////////////////////
  // Comparison and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // Valid held until its ready edge; bready held until bvalid
  task automatic wr(input logic [7:0] wAddr, input logic [31:0] d);
    int n;
    @(posedge clk);
    s_axi_awaddr <= wAddr;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'h0;
    if (n >= 50) n_fail++;
    chk({30'h0, s_axi_bresp}, 32'h0, "bresp");
  endtask : wr

  task automatic rc(input logic [7:0] rAddr, input logic [31:0] e);
    int n;
    @(posedge clk);
    s_axi_araddr <= rAddr;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'h0;
    if (n >= 50) n_fail++;
    chk({30'h0, s_axi_rresp}, 32'h0, "rresp");
    chk(s_axi_rdata, e, $sformatf("read %h", rAddr));
  endtask : rc

  //////////////////////////////////////////////////////////////////////////////
  // Expected register state
  function automatic logic [31:0] stv(input logic [7:0] ra);
    return (ra[3:0] == 4'h8) ? st[ra[7:4]] & LM : 32'h0;
  endfunction : stv

  // Func group inverts set/clear; 0x38 only under the write mask
  function automatic void apply(input logic [7:0] wAddr, input logic [31:0] d);
    logic [3:0] g;
    g = wAddr[7:4];
    d = d & LM;
    if (wAddr[3:0] == 4'h0 && g != 4'h7 || wAddr[3:0] == 4'h4 && g == 4'h7) st[g] |= d;
    else if (wAddr[3:0] == 4'h0 || wAddr[3:0] == 4'h4) st[g] &= ~d;
    else if (wAddr == 8'h38) st[3] = st[3] & ~st[10] | d & st[10];
    st[0] = (st[0] | ~MM) & LM;
  endfunction : apply

  task automatic finish_test();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_b = 1'h0;
    ctlClkOn = 1'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_wstrb = 4'hf;
    st = '{default: 32'h0};
    st[0] = (ORST | ~MM) & LM;
    prev = 32'h0;
    repeat (4) @(posedge clk);
    rst_b <= 1'h1;
    for (int i = 0; i < 44; i++) rc(8'(i * 4), stv(8'(i * 4)));
    $display("test reset values done");
    // Direct output write under a partial mask, then random writes
    wr(8'ha0, 32'h0000_ffff);
    apply(8'ha0, 32'h0000_ffff);
    wr(8'h38, 32'ha5a5_a5a5);
    apply(8'h38, 32'ha5a5_a5a5);
    rc(8'h38, stv(8'h38));
    repeat (60) begin
      a = wa[$unsigned($random(seed)) % 22];
      v = $random(seed);
      wr(a, v);
      apply(a, v);
      rc({a[7:4], 4'h8}, stv({a[7:4], 4'h8}));
      chk(ownerIsCtl & LM, st[0], "owner port");
      chk(funcBSelect & LM, st[7], "func port");
      chk(driveEnable & LM, st[1], "drive port");
      chk(outLevel & LM, st[3], "out port");
      chk(openDrain & LM, st[5], "od port");
      chk(pullupOff & LM, st[6], "pull port");
    end
    $display("test register writes done");
    // Pin traffic with whatever filter and mask state is left
    wr(8'h40, 32'h0f0f_0f0f);
    apply(8'h40, 32'h0f0f_0f0f);
    // Low two byte lanes only: filter on lines 0 to 15
    s_axi_wstrb <= 4'h3;
    wr(8'h20, 32'hffff_ffff);
    s_axi_wstrb <= 4'hf;
    apply(8'h20, 32'h0000_ffff);
    rc(8'h28, stv(8'h28));
    ctlClkOn <= 1'h1;
    repeat (8) begin
      v = $random(seed);
      PAD.step(v);
      repeat (6) @(posedge clk);
      chk(periphIn & LM, v & LM, "periph");
      chk({31'h0, changeIrq}, {31'h0, |((v ^ prev) & st[4])}, "irq");
      rc(8'h3c, v & LM);
      rc(8'h4c, (v ^ prev) & LM);
      rc(8'h4c, 32'h0);
      chk({31'h0, changeIrq}, 32'h0, "irq clear");
      prev = v;
    end
    PAD.glitch(32'h5555_5555);
    repeat (6) @(posedge clk);
    rc(8'h3c, prev & LM);
    rc(8'h4c, 32'h0);
    // A pulse of one full cycle must pass, filtered or not
    PAD.step(prev ^ 32'h00ff_00ff);
    PAD.step(prev);
    repeat (6) @(posedge clk);
    rc(8'h3c, prev & LM);
    rc(8'h4c, 32'h00ff_00ff);
    $display("test pins done");
    // Controller clock stopped: levels and flags freeze
    @(posedge clk);
    ctlClkOn <= 1'h0;
    v = ~prev;
    PAD.step(v);
    repeat (6) @(posedge clk);
    rc(8'h3c, prev & LM);
    rc(8'h4c, 32'h0);
    @(posedge clk);
    ctlClkOn <= 1'h1;
    repeat (6) @(posedge clk);
    rc(8'h3c, v & LM);
    rc(8'h4c, (v ^ prev) & LM);
    $display("test clock gate done");
    finish_test();
  end
endmodule : testbench
